/* File: src/rsu_device.sv */
// sensor responder end: frame receive, address and check, measurement reply
`timescale 1ns/1ps
`include "rsu_regs.svh"
module rsu_device #(
	parameter int BIT_CYC = `RSU_BIT_CYC,
	parameter int IDLE_CYC = `RSU_IDLE_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	rsu_link_if.dev link,
	input wire logic addr_load,
	input wire logic [7:0] addr_new,
	input wire logic [15:0] residual_rms_value,
	input wire logic [15:0] residual_dc_value,
	input wire logic general_fault,
	input wire logic calibration_active,
	input wire logic test_active,
	input wire logic switch_out_a,
	input wire logic switch_out_b,
	input wire logic error_free,
	input wire logic [7:0] status2,
	input wire logic [7:0] status3,
	output logic [7:0] node_addr,
	output logic reply_done,
	output logic crc_error
);
	import rsu_pkg::*;

	logic rx_s1_reg, rx_s2_reg;
	logic rx_busy_reg, rx_busy_next;
	logic [15:0] rx_cnt_reg, rx_cnt_next;
	logic [3:0] rx_bit_reg, rx_bit_next;
	logic [7:0] rx_sh_reg, rx_sh_next;
	logic in_frame_reg, in_frame_next;
	logic [23:0] gap_reg, gap_next;
	logic [7:0] nbytes_reg, nbytes_next;
	logic [7:0] hdr_addr_reg, hdr_addr_next, hdr_code_reg, hdr_code_next, hdr_len_reg, hdr_len_next;
	logic [15:0] crc_reg, crc_next, crc_d1_reg, crc_d1_next, crc_d2_reg, crc_d2_next;
	logic [7:0] b0_reg, b0_next, b1_reg, b1_next;
	rsu_dev_state_t st_reg, st_next;
	logic [3:0] tx_idx_reg, tx_idx_next, tx_bit_reg, tx_bit_next;
	logic [15:0] tx_cnt_reg, tx_cnt_next, tx_crc_reg, tx_crc_next;
	logic [7:0] rsp_mem [0:9];
	logic [7:0] rsp_next [0:9];
	logic txd_reg, txd_next, dir_reg, dir_next, done_reg, done_next, err_reg, err_next;
	logic [7:0] addr_reg, addr_next;
	logic byte_ok, crc_ok;
	logic [15:0] crc_base, rms_c, dc_c;
	logic [7:0] tx_byte;

	assign link.s2m_data = txd_reg;
	assign link.transceiver_direction = dir_reg;
	assign node_addr = addr_reg;
	assign reply_done = done_reg;
	assign crc_error = err_reg;

	always_comb
	begin
		rx_busy_next = rx_busy_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_bit_next = rx_bit_reg;
		rx_sh_next = rx_sh_reg;
		in_frame_next = in_frame_reg;
		gap_next = gap_reg;
		nbytes_next = nbytes_reg;
		hdr_addr_next = hdr_addr_reg;
		hdr_code_next = hdr_code_reg;
		hdr_len_next = hdr_len_reg;
		crc_next = crc_reg;
		crc_d1_next = crc_d1_reg;
		crc_d2_next = crc_d2_reg;
		b0_next = b0_reg;
		b1_next = b1_reg;
		st_next = st_reg;
		tx_idx_next = tx_idx_reg;
		tx_bit_next = tx_bit_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_crc_next = tx_crc_reg;
		for (int i = 0; i < 10; i++)
		begin
			rsp_next[i] = rsp_mem[i];
		end
		txd_next = 1'b1;
		dir_next = dir_reg;
		done_next = 1'b0;
		err_next = 1'b0;
		addr_next = addr_load ? addr_new : addr_reg;
		byte_ok = 1'b0;
		crc_base = (nbytes_reg == 8'h00) ? `RSU_CRC_INIT : crc_reg;
		crc_ok = (nbytes_reg >= `RSU_HDR_BYTES) && ({1'b0, nbytes_reg} == {1'b0, hdr_len_reg} + `RSU_HDR_BYTES)
			&& (crc_d2_reg == {b1_reg, b0_reg});
		rms_c = (residual_rms_value > `RSU_RMS_MAX) ? `RSU_RMS_MAX : residual_rms_value;
		dc_c = (residual_dc_value > `RSU_DC_MAX) ? `RSU_DC_MAX : residual_dc_value;
		tx_byte = (tx_idx_reg < 4'd10) ? rsp_mem[tx_idx_reg] :
			(tx_idx_reg == 4'd10) ? tx_crc_reg[15:8] : tx_crc_reg[7:0];

		// receiver: mid-bit sampling; deaf while replying
		if (!rx_busy_reg)
		begin
			if (!rx_s2_reg && st_reg == DEV_LISTEN)
			begin
				rx_busy_next = 1'b1;
				rx_cnt_next = 16'(BIT_CYC / 2);
				rx_bit_next = 4'd0;
			end
		end
		else if (rx_cnt_reg == 16'h0000)
		begin
			rx_cnt_next = 16'(BIT_CYC - 1);
			rx_bit_next = rx_bit_reg + 4'd1;
			if (rx_bit_reg == 4'd0 && rx_s2_reg)
				rx_busy_next = 1'b0;
			else if (rx_bit_reg >= 4'd1 && rx_bit_reg <= 4'd8)
				rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]};
			else if (rx_bit_reg == 4'd9)
			begin
				rx_busy_next = 1'b0;
				byte_ok = rx_s2_reg;
			end
		end
		else
			rx_cnt_next = rx_cnt_reg - 16'h0001;

		// framing; a bad stop bit drops only that byte
		if (byte_ok)
		begin
			in_frame_next = 1'b1;
			gap_next = 24'h000000;
			crc_d2_next = crc_d1_reg;
			crc_d1_next = crc_base;
			crc_next = rsu_crc_byte(crc_base, rx_sh_reg);
			b1_next = b0_reg;
			b0_next = rx_sh_reg;
			if (nbytes_reg == 8'h00)
				hdr_addr_next = rx_sh_reg;
			if (nbytes_reg == 8'h01)
				hdr_code_next = rx_sh_reg;
			if (nbytes_reg == 8'h02)
				hdr_len_next = rx_sh_reg;
			if (nbytes_reg != 8'hff)
				nbytes_next = nbytes_reg + 8'h01;
		end
		else if (rx_busy_reg)
			gap_next = 24'h000000;
		else if (in_frame_reg)
		begin
			gap_next = gap_reg + 24'h000001;
			if (gap_reg == 24'(IDLE_CYC - 1))
			begin
				in_frame_next = 1'b0;
				nbytes_next = 8'h00;
				if (nbytes_reg >= `RSU_HDR_BYTES && !crc_ok)
					err_next = 1'b1;
				// broadcast and foreign frames get no answer
				if (crc_ok && hdr_addr_reg == addr_reg && hdr_addr_reg != `RSU_BCAST_ADDR
					&& hdr_code_reg == `RSU_CMD_MEAS && hdr_len_reg == 8'h00)
				begin
					rsp_next[0] = addr_reg;
					rsp_next[1] = `RSU_CMD_MEAS;
					rsp_next[2] = `RSU_MEAS_LEN;
					rsp_next[3] = rms_c[15:8];
					rsp_next[4] = rms_c[7:0];
					rsp_next[5] = dc_c[15:8];
					rsp_next[6] = dc_c[7:0];
					rsp_next[7] = {general_fault, calibration_active, test_active, 2'b00,
						switch_out_b, switch_out_a, error_free};
					rsp_next[8] = {2'b00, status2[5:0]};
					rsp_next[9] = {4'h0, status3[3:0]};
					st_next = DEV_TX;
					dir_next = 1'b1;
					tx_idx_next = 4'd0;
					tx_bit_next = 4'd0;
					tx_cnt_next = 16'(BIT_CYC - 1);
					tx_crc_next = `RSU_CRC_INIT;
				end
			end
		end

		case (st_reg)
			DEV_LISTEN:
				txd_next = 1'b1;
			DEV_TX:
			begin
				if (tx_bit_reg == 4'd0)
					txd_next = 1'b0;
				else if (tx_bit_reg == 4'd9)
					txd_next = 1'b1;
				else
					txd_next = tx_byte[3'(tx_bit_reg - 4'd1)];
				if (tx_cnt_reg == 16'h0000)
				begin
					tx_cnt_next = 16'(BIT_CYC - 1);
					if (tx_bit_reg == 4'd9)
					begin
						tx_bit_next = 4'd0;
						if (tx_idx_reg < 4'd10)
							tx_crc_next = rsu_crc_byte(tx_crc_reg, tx_byte);
						if (tx_idx_reg == 4'd11)
						begin
							st_next = DEV_LISTEN;
							dir_next = 1'b0;
							done_next = 1'b1;
						end
						else
							tx_idx_next = tx_idx_reg + 4'd1;
					end
					else
						tx_bit_next = tx_bit_reg + 4'd1;
				end
				else
					tx_cnt_next = tx_cnt_reg - 16'h0001;
			end
			default:
			begin
				st_next = DEV_LISTEN;
				dir_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= 16'h0000;
			rx_bit_reg <= 4'd0;
			rx_sh_reg <= 8'h00;
			in_frame_reg <= 1'b0;
			gap_reg <= 24'h000000;
			nbytes_reg <= 8'h00;
			hdr_addr_reg <= 8'h00;
			hdr_code_reg <= 8'h00;
			hdr_len_reg <= 8'h00;
			crc_reg <= `RSU_CRC_INIT;
			crc_d1_reg <= `RSU_CRC_INIT;
			crc_d2_reg <= `RSU_CRC_INIT;
			b0_reg <= 8'h00;
			b1_reg <= 8'h00;
			st_reg <= DEV_LISTEN;
			tx_idx_reg <= 4'd0;
			tx_bit_reg <= 4'd0;
			tx_cnt_reg <= 16'h0000;
			tx_crc_reg <= `RSU_CRC_INIT;
			for (int i = 0; i < 10; i++)
			begin
				rsp_mem[i] <= 8'h00;
			end
			txd_reg <= 1'b1;
			dir_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			addr_reg <= `RSU_RESET_ADDR;
		end
		else
		begin
			rx_s1_reg <= link.m2s_data;
			rx_s2_reg <= rx_s1_reg;
			rx_busy_reg <= rx_busy_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_bit_reg <= rx_bit_next;
			rx_sh_reg <= rx_sh_next;
			in_frame_reg <= in_frame_next;
			gap_reg <= gap_next;
			nbytes_reg <= nbytes_next;
			hdr_addr_reg <= hdr_addr_next;
			hdr_code_reg <= hdr_code_next;
			hdr_len_reg <= hdr_len_next;
			crc_reg <= crc_next;
			crc_d1_reg <= crc_d1_next;
			crc_d2_reg <= crc_d2_next;
			b0_reg <= b0_next;
			b1_reg <= b1_next;
			st_reg <= st_next;
			tx_idx_reg <= tx_idx_next;
			tx_bit_reg <= tx_bit_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_crc_reg <= tx_crc_next;
			for (int i = 0; i < 10; i++)
			begin
				rsp_mem[i] <= rsp_next[i];
			end
			txd_reg <= txd_next;
			dir_reg <= dir_next;
			done_reg <= done_next;
			err_reg <= err_next;
			addr_reg <= addr_next;
		end
	end
endmodule

/* File: src/rsu_regs.svh */
// constants of the residual sensor serial link: timing, framing, controller register map
`ifndef RSU_REGS_SVH
`define RSU_REGS_SVH
`define RSU_CLK_HZ 100000000
`define RSU_BAUD 19200
`define RSU_BIT_CYC (`RSU_CLK_HZ / `RSU_BAUD)
`define RSU_GAP_BYTES 2
`define RSU_IDLE_CYC (`RSU_BIT_CYC * 10 * `RSU_GAP_BYTES + 1)
`define RSU_REPLY_MS 20
`define RSU_REPLY_CYC (`RSU_CLK_HZ / 1000 * `RSU_REPLY_MS)
`define RSU_SPACING_MS 50
`define RSU_SPACING_CYC (`RSU_CLK_HZ / 1000 * `RSU_SPACING_MS)
`define RSU_TMO_CYC (`RSU_REPLY_CYC + `RSU_RSP_BYTES * 10 * `RSU_BIT_CYC)
`define RSU_RESET_ADDR 8'h64
`define RSU_BCAST_ADDR 8'h00
`define RSU_CMD_MEAS 8'h01
`define RSU_MEAS_LEN 8'h07
`define RSU_RMS_MAX 16'h03e8
`define RSU_DC_MAX 16'h012c
`define RSU_CRC_INIT 16'hffff
`define RSU_CRC_POLY 16'ha001
`define RSU_HDR_BYTES 9'h005
`define RSU_RSP_BYTES 12
`define RSU_RETRIES 2'h2
`define RSU_CTRL_OFS 8'h00
`define RSU_STAT_OFS 8'h04
`define RSU_MEAS_OFS 8'h08
`define RSU_FLAG_OFS 8'h0c
`define RSU_CTRL_START 0
`define RSU_STAT_BUSY 0
`define RSU_STAT_DONE 1
`define RSU_STAT_DEFECT 2
`endif

/* File: src/rsu_pkg.sv */
// types and check-value function shared by both ends of the link
`include "rsu_regs.svh"
package rsu_pkg;
	typedef enum logic [1:0] {DEV_LISTEN = 2'b01, DEV_TX = 2'b10} rsu_dev_state_t;
	typedef enum logic [2:0] {M_IDLE = 3'b001, M_SEND = 3'b010, M_RECV = 3'b100} rsu_mst_state_t;

	// reflected bitwise form, same result as the 256-entry table
	function automatic logic [15:0] rsu_crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ `RSU_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

/* File: src/rsu_link_if.sv */
// serial link between master controller and sensor responder
`timescale 1ns/1ps
interface rsu_link_if;
	logic m2s_data;
	logic s2m_data;
	logic transceiver_direction;
	modport dev (input m2s_data, output s2m_data, output transceiver_direction);
	modport mst (output m2s_data, input s2m_data, input transceiver_direction);
endinterface

/* File: src/rsu_master.sv */
// master controller end: APB-driven measurement request with retries
`timescale 1ns/1ps
`include "rsu_regs.svh"
module rsu_master #(
	parameter int BIT_CYC = `RSU_BIT_CYC,
	parameter int SPACING_CYC = `RSU_SPACING_CYC,
	parameter int TMO_CYC = `RSU_TMO_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	rsu_link_if.mst link
);
	import rsu_pkg::*;

	rsu_mst_state_t st_reg, st_next;
	logic rx_s1_reg, rx_s2_reg;
	logic rx_busy_reg, rx_busy_next;
	logic [3:0] rx_bit_reg, rx_bit_next, bit_reg, bit_next, idx_reg, idx_next;
	logic [15:0] rx_cnt_reg, rx_cnt_next, cnt_reg, cnt_next, crc_reg, crc_next;
	logic [7:0] rx_sh_reg, rx_sh_next, tgt_reg, tgt_next;
	logic [7:0] rsp_mem [0:10];
	logic [7:0] rsp_next [0:10];
	logic [23:0] sp_reg, sp_next, tmo_reg, tmo_next;
	logic pend_reg, pend_next, done_reg, done_next, defect_reg, defect_next, txd_reg, txd_next;
	logic [1:0] tries_reg, tries_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pslverr_reg, pslverr_next;
	logic byte_ok, fail;
	logic [7:0] tx_byte;

	assign link.m2s_data = txd_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	always_comb
	begin
		st_next = st_reg;
		rx_busy_next = rx_busy_reg;
		rx_bit_next = rx_bit_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_sh_next = rx_sh_reg;
		bit_next = bit_reg;
		idx_next = idx_reg;
		cnt_next = cnt_reg;
		crc_next = crc_reg;
		tgt_next = tgt_reg;
		for (int i = 0; i < 11; i++)
		begin
			rsp_next[i] = rsp_mem[i];
		end
		sp_next = (sp_reg != 24'h000000) ? sp_reg - 24'h000001 : sp_reg;
		tmo_next = tmo_reg;
		pend_next = pend_reg;
		done_next = done_reg;
		defect_next = defect_reg;
		tries_next = tries_reg;
		txd_next = 1'b1;
		byte_ok = 1'b0;
		fail = 1'b0;
		case (idx_reg)
			4'd0: tx_byte = tgt_reg;
			4'd1: tx_byte = `RSU_CMD_MEAS;
			4'd3: tx_byte = crc_reg[15:8];
			4'd4: tx_byte = crc_reg[7:0];
			default: tx_byte = 8'h00;
		endcase

		// apb: zero-wait, answer registered in setup cycle
		prdata_next = 32'h00000000;
		pslverr_next = 1'b0;
		if (psel && !penable)
		begin
			case (paddr)
				`RSU_CTRL_OFS: prdata_next = {16'h0000, tgt_reg, 8'h00};
				`RSU_STAT_OFS: prdata_next = {26'h0, tries_reg, 1'b0, defect_reg, done_reg,
					pend_reg || st_reg != M_IDLE};
				`RSU_MEAS_OFS: prdata_next = {rsp_mem[3], rsp_mem[4], rsp_mem[5], rsp_mem[6]};
				`RSU_FLAG_OFS: prdata_next = {8'h00, rsp_mem[7], rsp_mem[8], rsp_mem[9]};
				default: pslverr_next = 1'b1;
			endcase
		end
		if (psel && penable && pready_reg && pwrite && paddr == `RSU_CTRL_OFS
			&& !pend_reg && st_reg == M_IDLE)
		begin
			tgt_next = pwdata[15:8];
			if (pwdata[`RSU_CTRL_START])
			begin
				pend_next = 1'b1;
				done_next = 1'b0;
				defect_next = 1'b0;
				tries_next = 2'h0;
			end
		end

		// receiver, listening only for the reply
		if (!rx_busy_reg)
		begin
			if (!rx_s2_reg && st_reg == M_RECV)
			begin
				rx_busy_next = 1'b1;
				rx_cnt_next = 16'(BIT_CYC / 2);
				rx_bit_next = 4'd0;
			end
		end
		else if (rx_cnt_reg == 16'h0000)
		begin
			rx_cnt_next = 16'(BIT_CYC - 1);
			rx_bit_next = rx_bit_reg + 4'd1;
			if (rx_bit_reg == 4'd0 && rx_s2_reg)
				rx_busy_next = 1'b0;
			else if (rx_bit_reg >= 4'd1 && rx_bit_reg <= 4'd8)
				rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]};
			else if (rx_bit_reg == 4'd9)
			begin
				rx_busy_next = 1'b0;
				byte_ok = rx_s2_reg;
			end
		end
		else
			rx_cnt_next = rx_cnt_reg - 16'h0001;

		case (st_reg)
			M_IDLE:
				if (pend_reg && sp_reg == 24'h000000)
				begin
					st_next = M_SEND;
					pend_next = 1'b0;
					idx_next = 4'd0;
					bit_next = 4'd0;
					cnt_next = 16'(BIT_CYC - 1);
					crc_next = `RSU_CRC_INIT;
					sp_next = 24'(SPACING_CYC - 1);
				end
			M_SEND:
			begin
				txd_next = (bit_reg == 4'd0) ? 1'b0 : (bit_reg == 4'd9) ? 1'b1 : tx_byte[3'(bit_reg - 4'd1)];
				if (cnt_reg == 16'h0000)
				begin
					cnt_next = 16'(BIT_CYC - 1);
					bit_next = (bit_reg == 4'd9) ? 4'd0 : bit_reg + 4'd1;
					if (bit_reg == 4'd9)
					begin
						idx_next = idx_reg + 4'd1;
						if (idx_reg < 4'd3)
							crc_next = rsu_crc_byte(crc_reg, tx_byte);
						if (idx_reg == 4'd4)
						begin
							st_next = M_RECV;
							idx_next = 4'd0;
							crc_next = `RSU_CRC_INIT;
							tmo_next = 24'(TMO_CYC - 1);
						end
					end
				end
				else
					cnt_next = cnt_reg - 16'h0001;
			end
			M_RECV:
			begin
				tmo_next = tmo_reg - 24'h000001;
				if (byte_ok)
				begin
					idx_next = idx_reg + 4'd1;
					if (idx_reg < 4'd11)
						rsp_next[idx_reg] = rx_sh_reg;
					if (idx_reg < 4'd10)
						crc_next = rsu_crc_byte(crc_reg, rx_sh_reg);
					if (idx_reg == 4'd11)
					begin
						st_next = M_IDLE;
						if ({rsp_mem[10], rx_sh_reg} == crc_reg && rsp_mem[0] == tgt_reg
							&& rsp_mem[1] == `RSU_CMD_MEAS && rsp_mem[2] == `RSU_MEAS_LEN)
							done_next = 1'b1;
						else
							fail = 1'b1;
					end
				end
				else if (tmo_reg == 24'h000000)
				begin
					st_next = M_IDLE;
					fail = 1'b1;
				end
			end
			default:
				st_next = M_IDLE;
		endcase

		if (fail)
		begin
			if (tries_reg < `RSU_RETRIES)
			begin
				tries_next = tries_reg + 2'h1;
				pend_next = 1'b1;
			end
			else
			begin
				defect_next = 1'b1;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= M_IDLE;
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_busy_reg <= 1'b0;
			rx_bit_reg <= 4'd0;
			rx_cnt_reg <= 16'h0000;
			rx_sh_reg <= 8'h00;
			bit_reg <= 4'd0;
			idx_reg <= 4'd0;
			cnt_reg <= 16'h0000;
			crc_reg <= `RSU_CRC_INIT;
			tgt_reg <= `RSU_RESET_ADDR;
			for (int i = 0; i < 11; i++)
			begin
				rsp_mem[i] <= 8'h00;
			end
			sp_reg <= 24'h000000;
			tmo_reg <= 24'h000000;
			pend_reg <= 1'b0;
			done_reg <= 1'b0;
			defect_reg <= 1'b0;
			tries_reg <= 2'h0;
			txd_reg <= 1'b1;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			rx_s1_reg <= link.s2m_data;
			rx_s2_reg <= rx_s1_reg;
			rx_busy_reg <= rx_busy_next;
			rx_bit_reg <= rx_bit_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_sh_reg <= rx_sh_next;
			bit_reg <= bit_next;
			idx_reg <= idx_next;
			cnt_reg <= cnt_next;
			crc_reg <= crc_next;
			tgt_reg <= tgt_next;
			for (int i = 0; i < 11; i++)
			begin
				rsp_mem[i] <= rsp_next[i];
			end
			sp_reg <= sp_next;
			tmo_reg <= tmo_next;
			pend_reg <= pend_next;
			done_reg <= done_next;
			defect_reg <= defect_next;
			tries_reg <= tries_next;
			txd_reg <= txd_next;
			prdata_reg <= prdata_next;
			pready_reg <= psel && !penable;
			pslverr_reg <= pslverr_next;
		end
	end
endmodule

/* File: tb/rsu_checker.sv */
// wire-level assertions on the link between master and responder
`timescale 1ns/1ps
module rsu_checker #(
	parameter int BIT_CYC = 16,
	parameter int REPLY_CYC = 2000000,
	parameter int SPACING_CYC = 5000000
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic m2s_data,
	input wire logic s2m_data,
	input wire logic transceiver_direction
);
	logic [31:0] quiet_reg;
	logic [31:0] low_reg;
	logic [31:0] dir_reg;
	logic req_reg;
	logic [31:0] since_reg;
	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// run counters kept in one block to stay small
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			quiet_reg <= '0;
			low_reg <= '0;
			dir_reg <= '0;
			req_reg <= 1'b0;
			// large start value: the first request has no predecessor
			since_reg <= 32'h40000000;
		end
		else
		begin
			quiet_reg <= m2s_data ? quiet_reg + 1 : '0;
			low_reg <= s2m_data ? '0 : low_reg + 1;
			dir_reg <= transceiver_direction ? dir_reg + 1 : '0;
			req_reg <= !m2s_data || (req_reg && !transceiver_direction);
			since_reg <= (!m2s_data && quiet_reg > 20 * BIT_CYC) ? '0 : since_reg + 1;
		end
	end
	property p_idle_high;
		!transceiver_direction |-> s2m_data;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("reply line active with driver off");
	property p_start_after_dir;
		$rose(transceiver_direction) |-> s2m_data ##[1:2] !s2m_data;
	endproperty
	a_start_after_dir: assert property (p_start_after_dir)
		else $error("no start bit after driver enable");
	property p_char_low;
		!s2m_data |-> low_reg <= 9 * BIT_CYC;
	endproperty
	a_char_low: assert property (p_char_low)
		else $error("reply line low beyond one character");
	property p_half_duplex;
		transceiver_direction |-> m2s_data;
	endproperty
	a_half_duplex: assert property (p_half_duplex)
		else $error("both directions active");
	property p_reply_after_req;
		$rose(transceiver_direction) |-> req_reg;
	endproperty
	a_reply_after_req: assert property (p_reply_after_req)
		else $error("reply without request");
	property p_gap_ends_frame;
		$rose(transceiver_direction) |-> quiet_reg > 20 * BIT_CYC;
	endproperty
	a_gap_ends_frame: assert property (p_gap_ends_frame)
		else $error("frame closed before idle gap");
	property p_reply_window;
		$rose(transceiver_direction) |-> quiet_reg < REPLY_CYC;
	endproperty
	a_reply_window: assert property (p_reply_window)
		else $error("reply started too late");
	property p_reply_len;
		$fell(transceiver_direction) |-> dir_reg >= 120 * BIT_CYC && dir_reg <= 120 * BIT_CYC + 2;
	endproperty
	a_reply_len: assert property (p_reply_len)
		else $error("reply not twelve characters long");
	property p_req_spacing;
		!m2s_data && quiet_reg > 20 * BIT_CYC |-> since_reg + 1 >= SPACING_CYC;
	endproperty
	a_req_spacing: assert property (p_req_spacing)
		else $error("requests closer than the minimum spacing");
endmodule

/* File: tb/tb_residual_sensor_uart_slave.sv */
// bench: master joined to responder, plus a responder fed by a rule-breaking driver
`timescale 1ns/1ps
module tb_residual_sensor_uart_slave;
	localparam int BIT = 16;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic addr_load = 1'b0;
	logic [7:0] addr_new = 8'h00;
	logic [15:0] rms = 16'h0;
	logic [15:0] dc = 16'h0;
	logic [5:0] fl = 6'h0;
	logic [7:0] st2 = 8'h00;
	logic [7:0] st3 = 8'h00;
	logic drv = 1'b1;
	logic [7:0] na;
	logic rd;
	logic ce2;
	logic [15:0] rmsc;
	logic [15:0] dcc;
	logic [7:0] st1;
	logic [31:0] q;
	logic e;
	int failures = 0;
	int checked = 0;
	int rd_cnt = 0;
	int ce_cnt = 0;
	int dir_cnt = 0;
	rsu_link_if link();
	rsu_link_if link2();
	assign link2.m2s_data = drv;
	assign rmsc = rms > 16'h03e8 ? 16'h03e8 : rms;
	assign dcc = dc > 16'h012c ? 16'h012c : dc;
	assign st1 = {fl[5:3], 2'b00, fl[2:0]};
	always #5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		rd_cnt <= rd_cnt + int'(rd === 1'b1);
		ce_cnt <= ce_cnt + int'(ce2 === 1'b1);
		dir_cnt <= dir_cnt + int'(link2.transceiver_direction === 1'b1);
	end
	rsu_master #(.BIT_CYC(BIT), .SPACING_CYC(2000), .TMO_CYC(4000)) rsu_master_inst (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link(link));
	rsu_device #(.BIT_CYC(BIT), .IDLE_CYC(20 * BIT + 1)) rsu_device_inst (.pclk, .presetn, .link(link), .addr_load,
		.addr_new, .residual_rms_value(rms), .residual_dc_value(dc), .general_fault(fl[5]),
		.calibration_active(fl[4]), .test_active(fl[3]), .switch_out_b(fl[2]), .switch_out_a(fl[1]),
		.error_free(fl[0]), .status2(st2), .status3(st3), .node_addr(na), .reply_done(rd), .crc_error());
	rsu_device #(.BIT_CYC(BIT), .IDLE_CYC(20 * BIT + 1)) rsu_device_inst2 (.pclk, .presetn, .link(link2),
		.addr_load(1'b0), .addr_new(8'h00), .residual_rms_value(rms), .residual_dc_value(dc),
		.general_fault(fl[5]), .calibration_active(fl[4]), .test_active(fl[3]), .switch_out_b(fl[2]),
		.switch_out_a(fl[1]), .error_free(fl[0]), .status2(st2), .status3(st3), .node_addr(), .reply_done(),
		.crc_error(ce2));
	rsu_checker #(.BIT_CYC(BIT), .SPACING_CYC(2000)) rsu_checker_inst (.pclk, .presetn, .m2s_data(link.m2s_data),
		.s2m_data(link.s2m_data), .transceiver_direction(link.transceiver_direction));
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		return c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			failures++;
			wrap_up;
		end
		@(posedge pclk);
	endtask
	task automatic wait_done;
		int n = 0;
		do
		begin
			apb(1'b0, 8'h04, 32'h0);
			n++;
		end
		while (q[1] !== 1'b1 && n < 10000);
		if (q[1] !== 1'b1)
		begin
			failures++;
			wrap_up;
		end
	endtask
	task automatic tx(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			drv <= f[i];
			repeat (BIT) @(posedge pclk);
		end
	endtask
	// samples mid-bit, so the caller is left in the stop bit
	task automatic rx(output logic [7:0] b);
		int n = 0;
		while (link2.s2m_data !== 1'b0 && n < 5000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 5000)
		begin
			failures++;
			wrap_up;
		end
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge pclk);
			b[i] = link2.s2m_data;
		end
		repeat (BIT) @(posedge pclk);
		chk(link2.s2m_data, 1);
	endtask
	task automatic dev_case(input logic [7:0] a, input logic bad, input logic want);
		logic [7:0] m [12];
		logic [7:0] b;
		logic [15:0] c = 16'hffff;
		int d0 = dir_cnt;
		int e0 = ce_cnt;
		m = '{a, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 3; i++)
			c = crc(c, m[i]);
		for (int i = 0; i < 5; i++)
			tx(i < 3 ? m[i] : (i == 3 ? c[15:8] : c[7:0] ^ {7'h0, bad}));
		if (want)
		begin
			m = '{8'h64, 8'h01, 8'h07, rmsc[15:8], rmsc[7:0], dcc[15:8], dcc[7:0], st1, st2 & 8'h3f,
				st3 & 8'h0f, 8'h00, 8'h00};
			c = 16'hffff;
			for (int i = 0; i < 10; i++)
				c = crc(c, m[i]);
			m[10] = c[15:8];
			m[11] = c[7:0];
			for (int i = 0; i < 12; i++)
			begin
				rx(b);
				chk(b, m[i]);
			end
			repeat (BIT) @(posedge pclk);
		end
		else
		begin
			repeat (1500) @(posedge pclk);
			chk(dir_cnt - d0, 0);
			chk(ce_cnt - e0, bad);
		end
	endtask
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h0000_6400);
		apb(1'b0, 8'h10, 32'h0);
		chk(e, 1);
		chk(q, 32'h0);
		chk(na, 8'h64);
		$display("test reset done");
		for (int k = 0; k < 2; k++)
		begin
			rms <= k ? 16'h03e9 : 16'h0123;
			dc <= k ? 16'hffff : 16'h012c;
			fl <= k ? 6'h14 : 6'h2b;
			st2 <= k ? 8'hc5 : 8'h3a;
			st3 <= k ? 8'hf3 : 8'h0c;
			apb(1'b1, 8'h00, 32'h0000_6401);
			wait_done;
			chk(q, 32'h2);
			apb(1'b0, 8'h08, 32'h0);
			chk(q, {rmsc, dcc});
			apb(1'b0, 8'h0c, 32'h0);
			chk(q, {8'h00, st1, st2 & 8'h3f, st3 & 8'h0f});
			dev_case(8'h64, 1'b0, 1'b1);
			chk(rd_cnt, k + 1);
			$display("test measurement %0d done", k);
		end
		dev_case(8'h64, 1'b1, 1'b0);
		dev_case(8'h00, 1'b0, 1'b0);
		dev_case(8'h65, 1'b0, 1'b0);
		$display("test refused frames done");
		addr_load <= 1'b1;
		addr_new <= 8'h2a;
		@(posedge pclk);
		addr_load <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(na, 8'h2a);
		apb(1'b1, 8'h00, 32'h0000_6401);
		wait_done;
		chk(q, 32'h26);
		apb(1'b1, 8'h00, 32'h0000_2a01);
		wait_done;
		chk(q, 32'h2);
		$display("test readdress done");
		wrap_up;
	end
endmodule
